// ==== hw/ssf_pkg.sv ====
// shared constants, types and helpers for the serial framer
`default_nettype none
package ssf_pkg;
	localparam int CLK_HZ = 100_000_000;
	// sub-unit ticks per unit time, so fractional stop lengths land on whole ticks
	localparam int OVS = 100;
	localparam logic [7:0] UNIT_LAST = 8'h63;
	localparam logic [7:0] HALF_LAST = 8'h31;
	localparam logic [7:0] UNIT_TK = 8'h64;
	localparam logic [7:0] STOP_142 = 8'h8E;
	localparam logic [7:0] STOP_150 = 8'h96;
	localparam logic [7:0] STOP_200 = 8'hC8;
	localparam logic [1:0] STOP_SEL_142 = 2'h0;
	localparam logic [1:0] STOP_SEL_150 = 2'h1;
	localparam logic [3:0] BITS_5 = 4'h5;
	localparam logic [3:0] BITS_7P = 4'h8;
	localparam logic [2:0] SY_BIT_LAST = 3'h7;
	// fixed sync character, wired in at build time (data then parity, lsb first)
	localparam logic [7:0] SYNC_PAT = 8'h96;
	localparam logic PAR_ODD = 1'b0;
	localparam logic MARK = 1'b1;
	localparam logic SPACE = 1'b0;

	typedef enum logic {SSF_FMT5 = 1'b0, SSF_FMT7P = 1'b1} ssf_fmt_t;

	typedef struct packed {
		ssf_fmt_t fmt;
		logic [1:0] stop_sel;
	} ssf_cfg_t;

	typedef struct packed {
		logic [6:0] data;
		logic perr;
		logic ferr;
	} ssf_char_t;

	function automatic logic ssf_parity(input logic [6:0] d);
		return (^d) ^ PAR_ODD;
	endfunction : ssf_parity

	function automatic logic [7:0] ssf_stop_ticks(input logic [1:0] sel);
		return (sel == STOP_SEL_142) ? STOP_142 : (sel == STOP_SEL_150) ? STOP_150 : STOP_200;
	endfunction : ssf_stop_ticks

	function automatic logic [3:0] ssf_nbits(input ssf_fmt_t f);
		return (f == SSF_FMT7P) ? BITS_7P : BITS_5;
	endfunction : ssf_nbits

	// whole character in sub-unit ticks: start + data/parity + stop
	function automatic logic [11:0] ssf_char_ticks(input ssf_cfg_t c);
		return 12'(UNIT_TK) + 12'(ssf_nbits(c.fmt)) * 12'(UNIT_TK) + 12'(ssf_stop_ticks(c.stop_sel));
	endfunction : ssf_char_ticks
endpackage : ssf_pkg
`default_nettype wire

// ==== hw/ssf_tick_gen.sv ====
// restartable divider giving one-cycle sub-unit tick enables
`timescale 1ns/1ps
`default_nettype none
module ssf_tick_gen #(
	parameter int DIV = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// phase restart and tick enable
	input wire logic clr,
	output logic tick
);
	localparam int W = $clog2(DIV + 1);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	// restart so the first tick lands DIV cycles after clr: the start element stays one unit long
	localparam logic [W-1:0] RESTART = W'(1 % DIV);
	localparam logic FIRST = (DIV == 1);

	logic [W-1:0] cnt_ff;
	wire logic at_last = (cnt_ff == LAST);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_ff <= '0;
			tick <= 1'b0;
		end
		else if (clr)
		begin
			cnt_ff <= RESTART;
			tick <= FIRST;
		end
		else
		begin
			cnt_ff <= at_last ? '0 : W'(cnt_ff + 1'b1);
			tick <= at_last;
		end
	end
endmodule : ssf_tick_gen
`default_nettype wire

// ==== hw/ssf_sync_port.sv ====
// synchronous character port: sync hunt, lock, deframing and sync-filled transmit
`timescale 1ns/1ps
`default_nettype none
module ssf_sync_port (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// line bit timing and data
	input wire logic bit_en,
	input wire logic rx_bit,
	input wire logic hunt,
	output logic tx_bit,
	// character side
	input wire logic tx_valid,
	input wire logic [6:0] tx_data,
	output logic tx_take,
	output logic locked,
	output logic rx_valid,
	output ssf_pkg::ssf_char_t rx_char
);
	logic [7:0] sh_ff;
	logic [2:0] cnt_ff;
	logic [7:0] tsh_ff;
	logic [2:0] tcnt_ff;

	// ********************
	// receive
	// ********************
	wire logic [7:0] win = {rx_bit, sh_ff[7:1]};
	wire logic is_sync = (win == ssf_pkg::SYNC_PAT); // RULE8
	wire logic char_end = locked && (cnt_ff == ssf_pkg::SY_BIT_LAST);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sh_ff <= 8'h00;
			cnt_ff <= 3'h0;
			locked <= 1'b0;
			rx_valid <= 1'b0;
			rx_char <= '0;
		end
		else
		begin
			rx_valid <= 1'b0;
			if (hunt)
				locked <= 1'b0;
			else if (bit_en)
			begin
				sh_ff <= win; // RULE9
				// filler sync characters between data are swallowed once locked
				if (!locked && is_sync)
				begin
					locked <= 1'b1; // RULE10
					cnt_ff <= 3'h0;
				end
				else if (char_end)
				begin
					cnt_ff <= 3'h0;
					rx_valid <= !is_sync; // RULE11
					rx_char <= '{data: win[6:0], perr: ssf_pkg::ssf_parity(win[6:0]) != win[7], ferr: 1'b0};
				end
				else if (locked)
					cnt_ff <= 3'(cnt_ff + 3'h1);
			end
		end
	end

	// ********************
	// transmit
	// ********************
	// idle time is filled with sync characters so the far end can lock at any point
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tsh_ff <= ssf_pkg::SYNC_PAT;
			tcnt_ff <= 3'h0;
			tx_bit <= ssf_pkg::MARK;
			tx_take <= 1'b0;
		end
		else
		begin
			tx_take <= 1'b0;
			if (bit_en)
			begin
				tx_bit <= tsh_ff[0];
				if (tcnt_ff == ssf_pkg::SY_BIT_LAST)
				begin
					tcnt_ff <= 3'h0;
					tsh_ff <= tx_valid ? {ssf_pkg::ssf_parity(tx_data), tx_data} : ssf_pkg::SYNC_PAT; // RULE13
					tx_take <= tx_valid;
				end
				else
				begin
					tcnt_ff <= 3'(tcnt_ff + 3'h1);
					tsh_ff <= {1'b0, tsh_ff[7:1]};
				end
			end
		end
	end

	// ********************
	// checks
	// ********************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_sy_hunt_lock: assert property (bit_en && !hunt && !locked && is_sync |=> locked) // RULE10
		else $error("sync match did not lock");
	a_sy_hunt_drop: assert property (hunt |=> !locked) // RULE9
		else $error("hunt did not drop lock");
	a_sy_no_filler: assert property (rx_valid |-> locked && $past(bit_en) && $past(!is_sync)) // RULE11
		else $error("sync filler delivered as data");
	a_sy_tx_char: assert property (tx_take |-> tsh_ff[7] == ssf_pkg::ssf_parity(tsh_ff[6:0]) && tcnt_ff == 3'h0) // RULE13
		else $error("sync transmit char lacks parity");
	c_sy_lock: cover property (!locked ##1 locked);
endmodule : ssf_sync_port
`default_nettype wire

// ==== hw/ssf_framer.sv ====
// start-stop, synchronous and strobed parallel character framer
// What this block does
// RULE1: line rests at mark between characters; transmitter holds mark when idle.
// RULE2: every async character starts with one space start element.
// RULE3: stop interval at mark lasts at least configured length, until next character.
// RULE4: receiver takes exactly the configured bits after start, then rests.
// RULE5: start element sets unit time; each data and parity bit lasts one unit.
// RULE6: stop of 1.42, 1.5 or 2 units; formats 5 data or 7+parity.
// RULE7: character period equals start+data+parity+stop units: 7.42, 10.50, 11.00.
// RULE8: synchronous receiver uses a fixed build-time sync pattern for alignment.
// RULE9: before lock, compare stream against sync pattern at every bit position.
// RULE10: on match, lock and split later bits on that boundary.
// RULE11: works with continuous sync filler or preamble-only sync characters.
// RULE12: lock is offered as a ready indication for a return circuit.
// RULE13: synchronous characters are data bits plus parity, no start or stop.
// RULE14: parallel leads are captured together only on the strobe.
// RULE15: async receiver samples each bit at unit centre counted from start edge.
`timescale 1ns/1ps
`default_nettype none
module ssf_framer #(
	parameter int BIT_RATE = 110
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// async format
	input wire ssf_pkg::ssf_cfg_t CFG,
	// async transmit
	input wire logic TX_VALID,
	input wire logic [6:0] TX_DATA,
	output logic TX_READY,
	output logic TX_LINE,
	// async receive
	input wire logic RX_LINE,
	output logic RX_VALID,
	output ssf_pkg::ssf_char_t RX_CHAR,
	// synchronous line
	input wire logic SY_BIT_EN,
	input wire logic SY_RX_BIT,
	input wire logic SY_HUNT,
	output logic SY_TX_BIT,
	output logic SY_LOCKED,
	// synchronous characters
	input wire logic SY_TX_VALID,
	input wire logic [6:0] SY_TX_DATA,
	output logic SY_TX_TAKEN,
	output logic SY_RX_VALID,
	output ssf_pkg::ssf_char_t SY_RX_CHAR,
	// strobed parallel receive
	input wire logic PAR_STB,
	input wire logic [6:0] PAR_LEADS,
	output logic PAR_VALID,
	output logic [6:0] PAR_DATA
);
	localparam int TICK_RAW = ssf_pkg::CLK_HZ / (BIT_RATE * ssf_pkg::OVS);
	localparam int TICK_DIV = (TICK_RAW > 0) ? TICK_RAW : 1;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_START = 4'b0010,
		ST_DATA = 4'b0100,
		ST_STOP = 4'b1000
	} ssf_state_t;

	// ********************
	// async transmit
	// ********************
	ssf_state_t tx_state_ff, nxt_tx_state;
	logic [7:0] tx_tk_ff, nxt_tx_tk;
	logic [3:0] tx_bit_ff, nxt_tx_bit;
	logic [7:0] tx_sh_ff, nxt_tx_sh;
	logic nxt_tx_line;
	logic nxt_tx_ready;
	ssf_pkg::ssf_cfg_t tx_cfg_ff, nxt_tx_cfg;
	logic tx_tick;

	wire logic tx_take = TX_VALID && TX_READY;
	wire logic [7:0] tx_word = (CFG.fmt == ssf_pkg::SSF_FMT7P) ?
		{ssf_pkg::ssf_parity(TX_DATA), TX_DATA} : {3'h0, TX_DATA[4:0]};
	wire logic [7:0] tx_stop_last = 8'(ssf_pkg::ssf_stop_ticks(tx_cfg_ff.stop_sel) - 8'h01);
	wire logic [3:0] tx_bit_last = 4'(ssf_pkg::ssf_nbits(tx_cfg_ff.fmt) - 4'h1);
	wire logic tx_unit_end = tx_tick && (tx_tk_ff == ssf_pkg::UNIT_LAST);

	// restarted at each accept so the start element is a whole unit
	ssf_tick_gen #(.DIV(TICK_DIV)) u_tx_tick (
		.clk(MCLK),
		.rst(RST),
		.clr(tx_take),
		.tick(tx_tick)
	);

	always_comb
	begin
		nxt_tx_state = tx_state_ff;
		nxt_tx_tk = tx_tk_ff;
		nxt_tx_bit = tx_bit_ff;
		nxt_tx_sh = tx_sh_ff;
		nxt_tx_line = TX_LINE;
		nxt_tx_ready = TX_READY;
		nxt_tx_cfg = tx_cfg_ff;
		unique case (tx_state_ff)
			ST_IDLE:
			begin
				nxt_tx_line = ssf_pkg::MARK; // RULE1
				if (tx_take)
				begin
					nxt_tx_state = ST_START;
					nxt_tx_line = ssf_pkg::SPACE; // RULE2
					nxt_tx_tk = 8'h00;
					nxt_tx_bit = 4'h0;
					nxt_tx_sh = tx_word;
					nxt_tx_cfg = CFG; // RULE6
					nxt_tx_ready = 1'b0;
				end
			end
			ST_START:
			begin
				if (tx_unit_end)
				begin
					nxt_tx_state = ST_DATA;
					nxt_tx_tk = 8'h00;
					nxt_tx_line = tx_sh_ff[0];
					nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
				end
				else if (tx_tick)
					nxt_tx_tk = 8'(tx_tk_ff + 8'h01);
			end
			ST_DATA:
			begin
				if (tx_unit_end) // RULE5
				begin
					nxt_tx_tk = 8'h00;
					if (tx_bit_ff == tx_bit_last)
					begin
						nxt_tx_state = ST_STOP;
						nxt_tx_line = ssf_pkg::MARK; // RULE3
					end
					else
					begin
						nxt_tx_bit = 4'(tx_bit_ff + 4'h1);
						nxt_tx_line = tx_sh_ff[0];
						nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
					end
				end
				else if (tx_tick)
					nxt_tx_tk = 8'(tx_tk_ff + 8'h01);
			end
			ST_STOP:
			begin
				// stop keeps going in idle at mark until the next character
				if (tx_tick && (tx_tk_ff == tx_stop_last)) // RULE7
				begin
					nxt_tx_state = ST_IDLE;
					nxt_tx_ready = 1'b1;
				end
				else if (tx_tick)
					nxt_tx_tk = 8'(tx_tk_ff + 8'h01);
			end
		endcase
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			tx_state_ff <= ST_IDLE;
			tx_tk_ff <= 8'h00;
			tx_bit_ff <= 4'h0;
			tx_sh_ff <= 8'h00;
			tx_cfg_ff <= '0;
			TX_LINE <= ssf_pkg::MARK;
			TX_READY <= 1'b1;
		end
		else
		begin
			tx_state_ff <= nxt_tx_state;
			tx_tk_ff <= nxt_tx_tk;
			tx_bit_ff <= nxt_tx_bit;
			tx_sh_ff <= nxt_tx_sh;
			tx_cfg_ff <= nxt_tx_cfg;
			TX_LINE <= nxt_tx_line;
			TX_READY <= nxt_tx_ready;
		end
	end

	// ********************
	// async receive
	// ********************
	ssf_state_t rx_state_ff;
	logic [7:0] rx_tk_ff;
	logic [3:0] rx_bit_ff;
	logic [7:0] rx_sh_ff;
	logic rx_prev_ff;
	ssf_pkg::ssf_fmt_t rx_fmt_ff;
	logic rx_tick;

	wire logic rx_edge = (rx_state_ff == ST_IDLE) && rx_prev_ff && !RX_LINE;
	wire logic rx_half = rx_tick && (rx_tk_ff == ssf_pkg::HALF_LAST);
	wire logic rx_unit = rx_tick && (rx_tk_ff == ssf_pkg::UNIT_LAST);
	wire logic [3:0] rx_bit_last = 4'(ssf_pkg::ssf_nbits(rx_fmt_ff) - 4'h1);
	wire logic rx_is7 = (rx_fmt_ff == ssf_pkg::SSF_FMT7P);
	wire logic [6:0] rx_data = rx_is7 ? rx_sh_ff[6:0] : {2'h0, rx_sh_ff[7:3]};
	wire logic rx_perr = rx_is7 && (ssf_pkg::ssf_parity(rx_sh_ff[6:0]) != rx_sh_ff[7]);
	wire logic [7:0] rx_tk_inc = rx_tick ? 8'(rx_tk_ff + 8'h01) : rx_tk_ff;

	// divider phase taken from the start edge, not free running
	ssf_tick_gen #(.DIV(TICK_DIV)) u_rx_tick (
		.clk(MCLK),
		.rst(RST),
		.clr(rx_edge), // RULE15
		.tick(rx_tick)
	);

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			rx_state_ff <= ST_IDLE;
			rx_tk_ff <= 8'h00;
			rx_bit_ff <= 4'h0;
			rx_sh_ff <= 8'h00;
			rx_prev_ff <= ssf_pkg::MARK;
			rx_fmt_ff <= ssf_pkg::SSF_FMT5;
			RX_VALID <= 1'b0;
			RX_CHAR <= '0;
		end
		else
		begin
			rx_prev_ff <= RX_LINE;
			RX_VALID <= 1'b0;
			rx_tk_ff <= rx_tk_inc;
			unique case (rx_state_ff)
				ST_IDLE:
				begin
					rx_tk_ff <= 8'h00;
					if (rx_edge)
					begin
						rx_state_ff <= ST_START;
						rx_fmt_ff <= CFG.fmt;
					end
				end
				ST_START:
				begin
					// a glitch shorter than half a unit is not a start
					if (rx_half)
					begin
						rx_state_ff <= RX_LINE ? ST_IDLE : ST_DATA; // RULE15
						rx_tk_ff <= 8'h00;
						rx_bit_ff <= 4'h0;
					end
				end
				ST_DATA:
				begin
					if (rx_unit)
					begin
						rx_tk_ff <= 8'h00;
						rx_sh_ff <= {RX_LINE, rx_sh_ff[7:1]}; // RULE15
						rx_bit_ff <= 4'(rx_bit_ff + 4'h1);
						if (rx_bit_ff == rx_bit_last)
							rx_state_ff <= ST_STOP; // RULE4
					end
				end
				ST_STOP:
				begin
					if (rx_unit)
					begin
						rx_state_ff <= ST_IDLE; // RULE4
						RX_VALID <= 1'b1;
						RX_CHAR <= '{data: rx_data, perr: rx_perr, ferr: !RX_LINE};
					end
				end
			endcase
		end
	end

	// ********************
	// synchronous port
	// ********************
	ssf_sync_port u_sync (
		.clk(MCLK),
		.rst(RST),
		.bit_en(SY_BIT_EN),
		.rx_bit(SY_RX_BIT),
		.hunt(SY_HUNT),
		.tx_bit(SY_TX_BIT),
		.tx_valid(SY_TX_VALID),
		.tx_data(SY_TX_DATA),
		.tx_take(SY_TX_TAKEN),
		.locked(SY_LOCKED), // RULE12
		.rx_valid(SY_RX_VALID),
		.rx_char(SY_RX_CHAR)
	);

	// ********************
	// strobed parallel receive
	// ********************
	logic par_stb_ff;

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			par_stb_ff <= 1'b0;
			PAR_VALID <= 1'b0;
			PAR_DATA <= 7'h00;
		end
		else
		begin
			par_stb_ff <= PAR_STB;
			PAR_VALID <= PAR_STB && !par_stb_ff;
			if (PAR_STB && !par_stb_ff)
				PAR_DATA <= PAR_LEADS; // RULE14
		end
	end

	// ********************
	// checks
	// ********************
	logic [11:0] frm_tk_ff;

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			frm_tk_ff <= 12'h000;
		else if (tx_take)
			frm_tk_ff <= 12'h000;
		else if (tx_tick && (tx_state_ff != ST_IDLE))
			frm_tk_ff <= 12'(frm_tk_ff + 12'h001);
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	a_tx_idle_mark: assert property (tx_state_ff == ST_IDLE && !$past(tx_state_ff == ST_STOP) |-> TX_LINE) // RULE1
		else $error("line not at mark while idle");
	a_tx_start_space: assert property (tx_take |=> !TX_LINE ##0 tx_state_ff == ST_START) // RULE2
		else $error("character did not open with start element");
	a_tx_stop_mark: assert property (tx_state_ff == ST_STOP |-> TX_LINE) // RULE3
		else $error("stop interval not at mark");
	a_rx_rest_after: assert property (RX_VALID |-> rx_state_ff == ST_IDLE && $past(rx_bit_ff) == ssf_pkg::ssf_nbits(rx_fmt_ff)) // RULE4
		else $error("receiver took wrong bit count");
	a_tx_bit_unit: assert property (tx_state_ff == ST_DATA && $changed(TX_LINE) |-> $past(tx_tk_ff) == ssf_pkg::UNIT_LAST) // RULE5
		else $error("data bit not one unit long");
	a_tx_stop_len: assert property (tx_state_ff == ST_STOP && tx_tick && tx_tk_ff == tx_stop_last |=> TX_READY) // RULE6
		else $error("stop length wrong");
	a_tx_char_period: assert property (tx_state_ff == ST_STOP && nxt_tx_state == ST_IDLE |-> 12'(frm_tk_ff + 12'h001) == ssf_pkg::ssf_char_ticks(tx_cfg_ff)) // RULE7
		else $error("character period differs from unit code");
	a_rx_false_start: assert property (rx_state_ff == ST_START && rx_half && RX_LINE |=> rx_state_ff == ST_IDLE) // RULE15
		else $error("false start not rejected");
	a_par_capture: assert property ($rose(PAR_STB) |=> PAR_VALID && PAR_DATA == $past(PAR_LEADS)) // RULE14
		else $error("parallel leads not captured on strobe");

	c_rx_char: cover property (RX_VALID && !RX_CHAR.ferr);
	c_tx_142: cover property (tx_state_ff == ST_STOP && tx_cfg_ff.stop_sel == ssf_pkg::STOP_SEL_142 ##1 tx_state_ff == ST_IDLE);
	c_par: cover property (PAR_VALID);
endmodule : ssf_framer
`default_nettype wire

// ==== dv/ssf_remote_term.sv ====
// remote start-stop terminal model facing the framer's serial lines
`timescale 1ns/1ps
`default_nettype none
module ssf_remote_term #(
	parameter int UNIT_CYC = 100
) (
	// clock
	input wire logic clk,
	// serial lines
	input wire logic line_in,
	output logic line_out
);
	initial line_out = ssf_pkg::MARK;

	// ****************************************
	// transmit one character toward the framer
	// ****************************************
	// stop_lvl low forces a broken stop element on purpose
	task automatic send(input logic [8:0] bits, input int nbits, input logic stop_lvl);
		@(posedge clk);
		line_out <= ssf_pkg::SPACE;
		repeat (UNIT_CYC) @(posedge clk);
		for (int i = 0; i < nbits; i++)
		begin
			line_out <= bits[i];
			repeat (UNIT_CYC) @(posedge clk);
		end
		line_out <= stop_lvl;
		repeat (2 * UNIT_CYC) @(posedge clk);
		line_out <= ssf_pkg::MARK;
		repeat (UNIT_CYC) @(posedge clk);
	endtask : send

	// short space pulse that must not be taken as a start element
	task automatic glitch(input int n);
		@(posedge clk);
		line_out <= ssf_pkg::SPACE;
		repeat (n) @(posedge clk);
		line_out <= ssf_pkg::MARK;
		repeat (2 * UNIT_CYC) @(posedge clk);
	endtask : glitch

	// ****************************************
	// receive one character, sampling at unit centres
	// ****************************************
	task automatic recv(input int nbits, output logic [8:0] bits, output logic ok);
		int w;
		bits = '0;
		w = 0;
		while (line_in !== 1'b0 && w < 20000)
		begin
			@(posedge clk);
			w++;
		end
		repeat (UNIT_CYC / 2) @(posedge clk);
		ok = (line_in === ssf_pkg::SPACE);
		for (int i = 0; i < nbits; i++)
		begin
			repeat (UNIT_CYC) @(posedge clk);
			bits[i] = line_in;
		end
		repeat (UNIT_CYC) @(posedge clk);
		ok = ok && (line_in === ssf_pkg::MARK);
	endtask : recv
endmodule : ssf_remote_term
`default_nettype wire

// ==== dv/ssf_framer_tb.sv ====
// self-checking bench for the serial framer
`timescale 1ns/1ps
`default_nettype none
module ssf_framer_tb;
	logic mclk, rst, tx_valid, tx_ready, tx_line, rx_line, rx_valid;
	logic sy_bit_en, sy_rx_bit, sy_hunt, sy_tx_bit, sy_locked, sy_tx_valid, sy_tx_taken, sy_rx_valid;
	logic par_stb, par_valid, sy_loop;
	logic [6:0] tx_data, sy_tx_data, par_leads, par_data;
	logic [1:0] div;
	ssf_pkg::ssf_cfg_t cfg;
	ssf_pkg::ssf_char_t rx_char, sy_rx_char;
	int err_count, checks, sy_rx_cnt, par_cnt, w;
	ssf_pkg::ssf_fmt_t t_fmt [3] = '{ssf_pkg::SSF_FMT5, ssf_pkg::SSF_FMT7P, ssf_pkg::SSF_FMT7P};
	logic [1:0] t_sel [3] = '{2'h0, 2'h1, 2'h2};
	logic [6:0] t_dat [3] = '{7'h15, 7'h4B, 7'h3C};
	int t_stop [3] = '{142, 150, 200};

	// one sub-unit tick per clock keeps a unit at 100 cycles
	ssf_framer #(.BIT_RATE(1_000_000)) u_ssf_framer (.MCLK(mclk), .RST(rst), .CFG(cfg),
		.TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready), .TX_LINE(tx_line),
		.RX_LINE(rx_line), .RX_VALID(rx_valid), .RX_CHAR(rx_char), .SY_BIT_EN(sy_bit_en),
		.SY_RX_BIT(sy_rx_bit), .SY_HUNT(sy_hunt), .SY_TX_BIT(sy_tx_bit), .SY_LOCKED(sy_locked),
		.SY_TX_VALID(sy_tx_valid), .SY_TX_DATA(sy_tx_data), .SY_TX_TAKEN(sy_tx_taken),
		.SY_RX_VALID(sy_rx_valid), .SY_RX_CHAR(sy_rx_char), .PAR_STB(par_stb), .PAR_LEADS(par_leads),
		.PAR_VALID(par_valid), .PAR_DATA(par_data));
	ssf_remote_term #(.UNIT_CYC(100)) u_ssf_remote_term (.clk(mclk), .line_in(tx_line), .line_out(rx_line));

	initial mclk = 1'b0;
	always #5 mclk = ~mclk;

	// ****************************************
	// synchronous bit timing and loopback
	// ****************************************
	// loopback lets the design's own filler stream serve as the remote sync source
	always @(posedge mclk)
	begin
		div <= div + 2'h1;
		sy_bit_en <= (div == 2'h3);
		sy_rx_bit <= sy_loop ? sy_tx_bit : 1'b0;
		if (sy_rx_valid === 1'b1) sy_rx_cnt++;
		if (par_valid === 1'b1) par_cnt++;
	end

	task automatic tick();
		@(posedge mclk);
		#1;
	endtask : tick

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin err_count++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	// ****************************************
	// async transmit, back to back over all formats
	// ****************************************
	task automatic tx_test();
		logic [8:0] bits;
		logic ok;
		logic [11:0] ex;
		int n, nb, lim;
		@(posedge mclk);
		cfg <= '{t_fmt[0], t_sel[0]};
		tx_data <= t_dat[0];
		tx_valid <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge mclk);
			nb = (t_fmt[i] == ssf_pkg::SSF_FMT7P) ? 8 : 5;
			// next format is set while this character runs: the framer must keep its own copy
			if (i == 2) tx_valid <= 1'b0;
			else begin cfg <= '{t_fmt[i + 1], t_sel[i + 1]}; tx_data <= t_dat[i + 1]; end
			fork
				u_ssf_remote_term.recv(nb, bits, ok);
				begin n = 0; do begin tick(); n++; end while (tx_ready !== 1'b1 && n < 3000); end
			join
			chk(12'(ok), 12'h1);
			ex = (nb == 8) ? {4'h0, (^t_dat[i]) ^ ssf_pkg::PAR_ODD, t_dat[i]} : {7'h0, t_dat[i][4:0]};
			chk((nb == 8) ? {3'h0, bits} : {7'h0, bits[4:0]}, ex);
			lim = 100 + nb * 100 + t_stop[i];
			chk(12'(n >= lim - 1 && n <= lim + 1), 12'h1);
		end
	endtask : tx_test

	// ****************************************
	// async receive with good and broken characters
	// ****************************************
	task automatic rx_case(input ssf_pkg::ssf_fmt_t f, input logic [1:0] sel, input logic [6:0] d,
		input logic bad_par, input logic bad_stop);
		logic [8:0] b;
		int n;
		ssf_pkg::ssf_char_t e;
		@(posedge mclk);
		cfg <= '{f, sel};
		e.ferr = bad_stop;
		if (f == ssf_pkg::SSF_FMT7P)
		begin
			b = {1'b0, (^d) ^ ssf_pkg::PAR_ODD ^ bad_par, d};
			n = 8;
			e.data = d;
			e.perr = bad_par;
		end
		else
		begin
			b = {4'h0, d[4:0]};
			n = 5;
			e.data = {2'h0, d[4:0]};
			e.perr = 1'b0;
		end
		fork
			u_ssf_remote_term.send(b, n, ~bad_stop);
			begin w = 0; do begin tick(); w++; end while (rx_valid !== 1'b1 && w < 3000); end
		join
		chk(12'(w < 3000), 12'h1);
		chk(12'(rx_char), 12'(e));
	endtask : rx_case

	initial
	begin
		#200_000;
		err_count++;
		tally_and_finish();
	end

	initial
	begin
		{rst, tx_valid, sy_bit_en, sy_rx_bit, sy_hunt, sy_tx_valid, par_stb, sy_loop} = 8'h80;
		{tx_data, sy_tx_data, par_leads, div} = '0;
		cfg = '{ssf_pkg::SSF_FMT5, 2'h0};
		err_count = 0;
		checks = 0;
		sy_rx_cnt = 0;
		par_cnt = 0;
		repeat (4) @(posedge mclk);
		chk({tx_line, tx_ready, sy_tx_bit, rx_valid, sy_locked, par_valid}, 12'h038);
		rst <= 1'b0;
		tx_test();
		rx_case(ssf_pkg::SSF_FMT5, 2'h0, 7'h0B, 1'b0, 1'b0);
		rx_case(ssf_pkg::SSF_FMT7P, 2'h1, 7'h55, 1'b0, 1'b0);
		rx_case(ssf_pkg::SSF_FMT7P, 2'h2, 7'h2C, 1'b1, 1'b0);
		rx_case(ssf_pkg::SSF_FMT5, 2'h0, 7'h11, 1'b0, 1'b1);
		fork
			u_ssf_remote_term.glitch(20);
			begin w = 0; do begin tick(); w++; end while (rx_valid !== 1'b1 && w < 250); end
		join
		chk(12'(w), 12'h0FA);

		// all-zero stream must never lock; filler must lock and stay silent
		@(posedge mclk);
		sy_hunt <= 1'b1;
		repeat (4) tick();
		sy_hunt <= 1'b0;
		repeat (60) tick();
		chk(12'(sy_locked), 12'h0);
		sy_loop <= 1'b1;
		w = 0;
		do begin tick(); w++; end while (sy_locked !== 1'b1 && w < 200);
		chk(12'(w < 200), 12'h1);
		sy_rx_cnt = 0;
		repeat (100) tick();
		chk(12'(sy_rx_cnt), 12'h0);
		sy_tx_data <= 7'h35;
		sy_tx_valid <= 1'b1;
		w = 0;
		do begin tick(); w++; end while (sy_tx_taken !== 1'b1 && w < 200);
		sy_tx_valid <= 1'b0;
		w = 0;
		do begin tick(); w++; end while (sy_rx_valid !== 1'b1 && w < 200);
		chk(12'(sy_rx_char), {3'h0, 7'h35, 2'h0});
		chk(12'(sy_locked), 12'h1);
		sy_hunt <= 1'b1;
		tick();
		tick();
		chk(12'(sy_locked), 12'h0);
		sy_hunt <= 1'b0;
		w = 0;
		do begin tick(); w++; end while (sy_locked !== 1'b1 && w < 200);
		chk(12'(w < 200), 12'h1);

		// strobed parallel leads
		par_cnt = 0;
		par_leads <= 7'h2A;
		repeat (3) tick();
		chk(12'(par_cnt), 12'h0);
		foreach (t_dat[i])
		begin
			par_leads <= t_dat[i];
			par_stb <= 1'b1;
			tick();
			chk({par_valid, 4'h0, par_data}, {1'b1, 4'h0, t_dat[i]});
			par_leads <= ~t_dat[i];
			tick();
			chk(12'(par_data), 12'(t_dat[i]));
			par_stb <= 1'b0;
			tick();
		end
		chk(12'(par_cnt), 12'h3);
		tally_and_finish();
	end
endmodule : ssf_framer_tb
`default_nettype wire
